// ==== kpi_pkg.sv ====
/*
  package for the keypad pin interrupt unit: register offsets, field positions,
  reset values and the carrier structs.
  assumes a 32-bit apb bus with word-aligned registers.
*/
package kpi_pkg;

  // register byte offsets
  localparam logic [7:0] KPI_OFS_STATUS_CTRL = 8'h00;
  localparam logic [7:0] KPI_OFS_PIN_ENABLE  = 8'h04;
  localparam logic [7:0] KPI_OFS_POLARITY    = 8'h08;
  localparam logic [7:0] KPI_OFS_IRQ_STATUS  = 8'h0c;
  localparam logic [7:0] KPI_OFS_IRQ_ENABLE  = 8'h10;
  localparam logic [7:0] KPI_OFS_IRQ_CLEAR   = 8'h14;

  // status/control field positions
  localparam int KPI_BIT_FLAG = 3;
  localparam int KPI_BIT_ACK  = 2;
  localparam int KPI_BIT_IE   = 1;
  localparam int KPI_BIT_MODE = 0;

  // event status bit positions
  localparam int KPI_EV_EDGE  = 0;
  localparam int KPI_EV_LEVEL = 1;
  localparam int KPI_EV_NUM   = 2;

  // reset values
  localparam logic [7:0] KPI_RST_PIN_ENABLE = 8'h00;
  localparam logic [7:0] KPI_RST_POLARITY   = 8'h00;
  localparam logic [1:0] KPI_RST_EVENT      = 2'h0;

  // apb request
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } kpi_apb_req_s;

  // apb answer
  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } kpi_apb_rsp_s;

endpackage

// ==== kpi_top.sv ====
/*
  keypad pin interrupt unit: eight pin inputs, per-pin enable and polarity,
  edge-only or edge-and-level detection, one sticky flag and one key request, plus two sticky event status bits with their own request,
  with an apb slave for software access.
  assumes pins are asynchronous to I_MCLK; wake from the deep stop modes
  is signalled by asserting I_RESETN low.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1 - status/control bits 7 to 4 always read zero
// RULE2 - flag bit 3 shows a detected event; writes leave it alone
// RULE3 - writing 1 to ack bit 2 clears the flag; ack reads 0
// RULE4 - request presented only while interrupt enable and flag both set
// RULE5 - mode bit 0: edges only when 0, edges and levels when 1
// RULE6 - pin enable bit 1 makes that pin a source; 0 ignores it
// RULE7 - polarity bit 0 falling/low, 1 rising/high per pin
// RULE8 - falling edge: sampled 1 then 0 on consecutive cycles
// RULE9 - rising edge: sampled 0 then 1 on consecutive cycles
// RULE10 - after an edge, no new edge until all enabled inputs deasserted
// RULE11 - edge-only mode: valid edge on enabled pin sets the flag
// RULE12 - edge-and-level mode: edge or asserted level sets the flag
// RULE13 - level mode: ack clears only if all enabled inputs deasserted
// RULE14 - polarity chooses pullup when 0, pulldown when 1 if pull enabled
// RULE15 - software masks, sets polarity, pulls, enables, acks, then unmasks
// RULE16 - eight independent inputs merged into one flag and one request
// RULE17 - wake from deepest stop modes returns whole unit to reset state
// RULE18 - reset clears all registers: pins off, masked, falling edge, flag clear
module kpi_top #(
  parameter int NPINS = 8
) (
  // clock and reset
  input  wire logic              I_MCLK,
  input  wire logic              I_RESETN,
  // apb slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [7:0]        I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  output logic [31:0]            O_PRDATA,
  // pins
  input  wire logic [NPINS-1:0]  I_KEY_PIN,
  input  wire logic [NPINS-1:0]  I_PORT_PULL_ENABLE,
  // pull control and interrupts
  output logic [NPINS-1:0]       O_PULLUP_EN,
  output logic [NPINS-1:0]       O_PULLDOWN_EN,
  output logic                   O_KEY_IRQ,
  output logic                   O_EVENT_IRQ
);

  logic                  rst_meta_r;
  logic                  rst_sync_r;
  logic                  rst_n;

  logic [NPINS-1:0]      pin_meta_r;
  logic [NPINS-1:0]      pin_sync_r;
  logic [NPINS-1:0]      pin_prev_r;
  logic [NPINS-1:0]      pull_meta_r;
  logic [NPINS-1:0]      pull_sync_r;

  logic [NPINS-1:0]      pin_enable_bits_r;
  logic [NPINS-1:0]      polarity_select_bits_r;
  logic                  key_irq_enable_r;
  logic                  detect_level_mode_r;
  logic                  key_event_flag_r;
  logic                  edge_armed_r;
  logic [kpi_pkg::KPI_EV_NUM-1:0] ev_status_r;
  logic [kpi_pkg::KPI_EV_NUM-1:0] ev_enable_r;

  logic [NPINS-1:0]      asserted_now;
  logic [NPINS-1:0]      asserted_prev;
  logic [NPINS-1:0]      edge_hit;
  logic                  any_edge;
  logic                  any_level;
  logic                  set_flag;
  logic                  all_idle;
  logic                  key_flag_ack;
  logic                  ack_clears;
  logic [kpi_pkg::KPI_EV_NUM-1:0] ev_set;

  kpi_pkg::kpi_apb_req_s req;
  logic                  wr_en;
  logic                  rd_en;
  logic                  addr_ok;
  logic [31:0]           rdata_nxt;

  assign req = '{sel: I_PSEL, enable: I_PENABLE, write: I_PWRITE,
                 addr: I_PADDR, wdata: I_PWDATA};

  // reset release; also the path used on wake from deep stop [RULE17]
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // pins are asynchronous: two-stage sampling before detection
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r  <= '0;
      pin_sync_r  <= '0;
      pin_prev_r  <= '0;
      pull_meta_r <= '0;
      pull_sync_r <= '0;
    end else begin
      pin_meta_r  <= I_KEY_PIN;
      pin_sync_r  <= pin_meta_r;
      pin_prev_r  <= pin_sync_r;
      pull_meta_r <= I_PORT_PULL_ENABLE;
      pull_sync_r <= pull_meta_r;
    end
  end

  // per-pin polarity and enable; eight independent sources [RULE16]
  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    // polarity 0 means active low, 1 active high [RULE7]
    assign asserted_now[g]  = pin_enable_bits_r[g] &
                              (pin_sync_r[g] ~^ polarity_select_bits_r[g]); // [RULE6]
    assign asserted_prev[g] = pin_prev_r[g] ~^ polarity_select_bits_r[g];
    // deasserted one cycle, asserted the next [RULE8] [RULE9]
    assign edge_hit[g]      = asserted_now[g] & ~asserted_prev[g];
  end

  assign all_idle  = ~|asserted_now;
  // edges are blocked until every enabled input has gone idle [RULE10]
  assign any_edge  = edge_armed_r & |edge_hit;
  assign any_level = detect_level_mode_r & ~all_idle;
  // edge always sets; level only in edge-and-level mode [RULE5] [RULE11] [RULE12]
  assign set_flag  = any_edge | any_level;

  // apb decode; zero wait states
  assign wr_en   = req.sel & req.enable & req.write;
  assign rd_en   = req.sel & ~req.enable & ~req.write;
  assign addr_ok = (req.addr == kpi_pkg::KPI_OFS_STATUS_CTRL) ||
                   (req.addr == kpi_pkg::KPI_OFS_PIN_ENABLE)  ||
                   (req.addr == kpi_pkg::KPI_OFS_POLARITY)    ||
                   (req.addr == kpi_pkg::KPI_OFS_IRQ_STATUS)  ||
                   (req.addr == kpi_pkg::KPI_OFS_IRQ_ENABLE)  ||
                   (req.addr == kpi_pkg::KPI_OFS_IRQ_CLEAR);

  assign key_flag_ack = wr_en & (req.addr == kpi_pkg::KPI_OFS_STATUS_CTRL) &
                        req.wdata[kpi_pkg::KPI_BIT_ACK]; // [RULE3]
  // in level mode a still-asserted pin keeps the flag [RULE13]
  assign ack_clears   = key_flag_ack & (~detect_level_mode_r | all_idle);

  // control registers [RULE18]
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_enable_bits_r      <= '0;
      polarity_select_bits_r <= '0;
      key_irq_enable_r       <= 1'b0;
      detect_level_mode_r    <= 1'b0;
      ev_enable_r            <= kpi_pkg::KPI_RST_EVENT;
    end else if (wr_en) begin
      case (req.addr)
        kpi_pkg::KPI_OFS_STATUS_CTRL: begin
          key_irq_enable_r    <= req.wdata[kpi_pkg::KPI_BIT_IE];
          detect_level_mode_r <= req.wdata[kpi_pkg::KPI_BIT_MODE];
        end
        kpi_pkg::KPI_OFS_PIN_ENABLE: pin_enable_bits_r      <= req.wdata[NPINS-1:0];
        kpi_pkg::KPI_OFS_POLARITY:   polarity_select_bits_r <= req.wdata[NPINS-1:0];
        kpi_pkg::KPI_OFS_IRQ_ENABLE: ev_enable_r <= req.wdata[kpi_pkg::KPI_EV_NUM-1:0];
        default: begin
        end
      endcase
    end
  end

  // shared flag; a set in the ack cycle wins over the clear [RULE2]
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      key_event_flag_r <= 1'b0;
    end else if (set_flag) begin
      key_event_flag_r <= 1'b1;
    end else if (ack_clears) begin
      key_event_flag_r <= 1'b0;
    end
  end

  // edge detector rearms only once every enabled pin is idle [RULE10]
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      edge_armed_r <= 1'b0;
    end else if (all_idle) begin
      edge_armed_r <= 1'b1;
    end else if (|edge_hit) begin
      edge_armed_r <= 1'b0;
    end
  end

  // sticky event status; set wins over the write-one clear
  assign ev_set = {any_level, any_edge};
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ev_status_r <= kpi_pkg::KPI_RST_EVENT;
    end else if (wr_en && req.addr == kpi_pkg::KPI_OFS_IRQ_CLEAR) begin
      ev_status_r <= ev_set | (ev_status_r & ~req.wdata[kpi_pkg::KPI_EV_NUM-1:0]);
    end else begin
      ev_status_r <= ev_status_r | ev_set;
    end
  end

  // read mux; unused bits and ack read zero [RULE1] [RULE3]
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (req.addr)
      kpi_pkg::KPI_OFS_STATUS_CTRL: begin
        rdata_nxt[kpi_pkg::KPI_BIT_FLAG] = key_event_flag_r;
        rdata_nxt[kpi_pkg::KPI_BIT_IE]   = key_irq_enable_r;
        rdata_nxt[kpi_pkg::KPI_BIT_MODE] = detect_level_mode_r;
      end
      kpi_pkg::KPI_OFS_PIN_ENABLE: rdata_nxt[NPINS-1:0] = pin_enable_bits_r;
      kpi_pkg::KPI_OFS_POLARITY:   rdata_nxt[NPINS-1:0] = polarity_select_bits_r;
      kpi_pkg::KPI_OFS_IRQ_STATUS: rdata_nxt[kpi_pkg::KPI_EV_NUM-1:0] = ev_status_r;
      kpi_pkg::KPI_OFS_IRQ_ENABLE: rdata_nxt[kpi_pkg::KPI_EV_NUM-1:0] = ev_enable_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data registered in setup so access phase needs no wait
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PRDATA  <= 32'h0000_0000;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      if (rd_en) begin
        O_PRDATA <= rdata_nxt;
      end
      // ready during access phase, one cycle after setup
      O_PREADY  <= req.sel & ~req.enable;
      O_PSLVERR <= req.sel & ~req.enable & ~addr_ok;
    end
  end

  // outputs straight from flops
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_KEY_IRQ     <= 1'b0;
      O_EVENT_IRQ   <= 1'b0;
      O_PULLUP_EN   <= '0;
      O_PULLDOWN_EN <= '0;
    end else begin
      // request gated by enable [RULE4]
      O_KEY_IRQ     <= key_irq_enable_r & key_event_flag_r;
      O_EVENT_IRQ   <= |(ev_status_r & ev_enable_r);
      // pull direction follows polarity [RULE14]
      O_PULLUP_EN   <= pull_sync_r & pin_enable_bits_r & ~polarity_select_bits_r;
      O_PULLDOWN_EN <= pull_sync_r & pin_enable_bits_r & polarity_select_bits_r;
    end
  end

endmodule

`default_nettype wire

// ==== kpi_checker_sva.sv ====
/* assertions for the keypad pin unit: apb timing, read-back, irq gating.
   sees only top ports; shadows register writes to know the setup. */
`timescale 1ns/1ps
`default_nettype none
module kpi_checker #(
  parameter int NPINS = 8
) (
  input wire logic             I_MCLK,
  input wire logic             I_RESETN,
  input wire logic             I_PSEL,
  input wire logic             I_PENABLE,
  input wire logic             I_PWRITE,
  input wire logic [7:0]       I_PADDR,
  input wire logic [31:0]      I_PWDATA,
  input wire logic             O_PREADY,
  input wire logic             O_PSLVERR,
  input wire logic [31:0]      O_PRDATA,
  input wire logic [NPINS-1:0] I_KEY_PIN,
  input wire logic [NPINS-1:0] O_PULLUP_EN,
  input wire logic [NPINS-1:0] O_PULLDOWN_EN,
  input wire logic             O_KEY_IRQ,
  input wire logic             O_EVENT_IRQ
);
  logic [NPINS-1:0] pe_r, pol_r;
  logic             ie_r, mode_r;
  logic [1:0]       een_r;
  wire logic wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
  wire logic rd = I_PSEL && I_PENABLE && !I_PWRITE && O_PREADY;
  wire logic [NPINS-1:0] act = pe_r & ~(I_KEY_PIN ^ pol_r);
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      {pe_r, pol_r, ie_r, mode_r, een_r} <= '0;
    end else if (wr) begin
      if (I_PADDR == 8'h00) {ie_r, mode_r} <= I_PWDATA[1:0];
      if (I_PADDR == 8'h04) pe_r <= I_PWDATA[NPINS-1:0];
      if (I_PADDR == 8'h08) pol_r <= I_PWDATA[NPINS-1:0];
      if (I_PADDR == 8'h10) een_r <= I_PWDATA[1:0];
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_setup;
    I_PSEL && !I_PENABLE;
  endsequence
  sequence s_lvl_held;
    (mode_r && ie_r && |act) [*6];
  endsequence
  a_ready_slot: assert property (s_setup |=> O_PREADY) else $error("no ready after setup");
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("ready too long");
  a_slverr_map: assert property (O_PREADY |-> O_PSLVERR == (I_PADDR > 8'h14 ||
    I_PADDR[1:0] != 2'h0)) else $error("error response wrong");
  a_ctrl_read: assert property (rd && I_PADDR == 8'h00 |-> O_PRDATA[7:4] == 4'h0 &&
    !O_PRDATA[2] && O_PRDATA[1:0] == {ie_r, mode_r}) else $error("control read wrong");
  a_enable_read: assert property (rd && I_PADDR == 8'h04 |-> O_PRDATA == 32'(pe_r))
    else $error("pin enable read wrong");
  a_polarity_read: assert property (rd && I_PADDR == 8'h08 |-> O_PRDATA == 32'(pol_r))
    else $error("polarity read wrong");
  a_irq_mask: assert property (!ie_r [*2] |-> !O_KEY_IRQ) else $error("masked irq seen");
  a_level_keep: assert property (s_lvl_held |-> O_KEY_IRQ) else $error("level lost");
  a_event_mask: assert property (een_r == 2'h0 [*2] |-> !O_EVENT_IRQ) else $error("event irq");
  a_pull_kind: assert property ($stable(pol_r) && $stable(pe_r) |->
    (O_PULLUP_EN & (~pe_r | pol_r)) == '0 && (O_PULLDOWN_EN & (~pe_r | ~pol_r)) == '0)
    else $error("pull kind wrong");
endmodule
bind kpi_top kpi_checker #(.NPINS(NPINS)) kpi_checker_i (.*);
`default_nettype wire

// ==== kpi_pin_model.sv ====
/* pin sources for the keypad unit: driven switches, else pulls, else drift.
   assumes the bench picks which pins are driven. */
`timescale 1ns/1ps
`default_nettype none
module kpi_pin_model (
  // clock and bench control
  input  wire logic       i_clk,
  input  wire logic [7:0] i_drive,
  input  wire logic [7:0] i_level,
  // pull state from the unit
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_pulldown,
  // pins
  output var logic [7:0]  o_pin
);
  logic [7:0] noise_r = 8'h5a;
  always_ff @(posedge i_clk) noise_r <= ~noise_r ^ {noise_r[6:0], noise_r[7]};
  // floating pins follow noise_r, which locks at 8'hff after five clocks, so they settle high
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      o_pin[k] = i_drive[k] ? i_level[k] : i_pullup[k] ? 1'b1 :
                 i_pulldown[k] ? 1'b0 : noise_r[k];
    end
  end
endmodule
`default_nettype wire

// ==== keyboard_pin_interrupt_test.sv ====
/* self-checking bench for the keypad pin unit: apb master, pin model, flag model.
   assumes a 20 MHz clock and zero-wait apb answers. */
`timescale 1ns/1ps
`default_nettype none
module keyboard_pin_interrupt_test;
  logic clk = 0, rst_n = 0, pready, pslverr, irq, ev_irq, err;
  kpi_pkg::kpi_apb_req_s req = '0;
  logic [31:0] prdata, rv;
  logic [7:0] pins, pu, pd, drv = '0, lvl = '0, pull = '0, en, idle;
  int n_mismatch = 0, comparisons = 0, seed = 25129, p, m_flag = 0, m_ie = 0, m_mode = 0;
  initial forever #25 clk = ~clk;
  kpi_top kpi_top_i (.I_MCLK(clk), .I_RESETN(rst_n), .I_PSEL(req.sel),
    .I_PENABLE(req.enable), .I_PWRITE(req.write), .I_PADDR(req.addr), .I_PWDATA(req.wdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata), .I_KEY_PIN(pins),
    .I_PORT_PULL_ENABLE(pull), .O_PULLUP_EN(pu), .O_PULLDOWN_EN(pd), .O_KEY_IRQ(irq),
    .O_EVENT_IRQ(ev_irq));
  kpi_pin_model kpi_pin_model_i (.i_clk(clk), .i_drive(drv), .i_level(lvl), .i_pullup(pu),
    .i_pulldown(pd), .o_pin(pins));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{sel: 1'b1, enable: 1'b0, write: w, addr: a, wdata: d};
    @(posedge clk);
    req.enable <= 1'b1;
    // only the watchdog ends a stuck access phase
    do @(posedge clk); while (pready !== 1'b1);
    chk("pready", 1, pready);
    rv = prdata;
    err = pslverr;
    req.sel <= 1'b0;
    req.enable <= 1'b0;
  endtask
  // model view of irq and the control register
  task automatic look();
    chk("irq", 32'(m_flag & m_ie), irq);
    apb(0, 8'h00, 0);
    chk("ctrl", 32'(m_flag * 8 + m_ie * 2 + m_mode), rv);
  endtask
  task automatic ctl(input logic [31:0] d, input int f);
    apb(1, 8'h00, d);
    {m_ie, m_mode, m_flag} = {31'h0, d[1], 31'h0, d[0], f};
    repeat (3) @(posedge clk);
    look();
  endtask
  task automatic pin(input logic [7:0] l, input int f);
    lvl <= l;
    repeat (8) @(posedge clk);
    m_flag = f;
    look();
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    pull <= 8'($random(seed));
    repeat (3) @(posedge clk);
    for (p = 0; p < 12; p += 4) begin
      apb(0, 8'(p), 0);
      chk("reset_value", 0, rv);
    end
    apb(0, 8'h40, 0);
    chk("unmapped_err", 1, err);
    ctl(32'hff, 0);
    for (p = 0; p < 2; p++) begin
      en = 8'($random(seed)) | 8'h03;
      idle = {8{~p[0]}};
      ctl(0, 0);
      apb(1, 8'h08, 32'(~idle));
      drv <= en;
      lvl <= idle;
      apb(1, 8'h04, 32'(en));
      ctl(4, 0);
      chk("pullup", 32'(pull & en & idle), 32'(pu));
      chk("pulldown", 32'(pull & en & ~idle), 32'(pd));
      ctl(2, 0);
      pin(idle ^ 8'h01, 1);
      ctl(0, 1);
      ctl(6, 0);
      pin(idle ^ 8'h03, 0);
      pin(idle, 0);
      pin(idle ^ 8'h02, 1);
      ctl(7, 1);
      pin(idle, 1);
      ctl(7, 0);
      ctl(2, 0);
    end
    // level events from the loop are still sticky; start from a clean status
    apb(1, 8'h14, 3);
    apb(1, 8'h10, 1);
    pin(8'h01, 1);
    chk("event_irq", 1, ev_irq);
    apb(0, 8'h0c, 0);
    chk("event_status", 1, rv);
    apb(1, 8'h10, 0);
    repeat (3) @(posedge clk);
    chk("event_masked", 0, ev_irq);
    apb(1, 8'h14, 3);
    apb(1, 8'h10, 1);
    repeat (3) @(posedge clk);
    chk("event_cleared", 0, ev_irq);
    apb(0, 8'h0c, 0);
    chk("event_status_clr", 0, rv);
    // wake from deep stop: reset in mid-run with the flag set
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (p = 0; p < 20; p += 4) begin
      apb(0, 8'(p), 0);
      chk("wake_value", 0, rv);
    end
    chk("wake_irq", 0, irq);
    wrap_up();
  end
endmodule
`default_nettype wire
